// >>> rtl/fpc_pkg.sv
// Constants, field positions and types of the foldback power control
package fpc_pkg;
  // Clock and step timing
  localparam int unsigned CLK_PERIOD_NS     = 8;
  localparam int unsigned STEP512_PERIOD_NS = 1953125;
  localparam int unsigned STEP512_CYC       = STEP512_PERIOD_NS / CLK_PERIOD_NS;
  localparam int unsigned PRE_W             = 18;
  localparam int unsigned TICK_W            = 13;
  // Slower rates as counts of 512 Hz ticks
  localparam logic [TICK_W-1:0] DIV_4HZ_MASK    = 13'h007f;
  localparam logic [TICK_W-1:0] DIV_2HZ_MASK    = 13'h00ff;
  localparam logic [TICK_W-1:0] DIV_1_16HZ_MASK = 13'h1fff;
  localparam int unsigned       FLASH_BIT       = 7;

  // Power control counter
  localparam int unsigned         CNT_W   = 8;
  localparam logic [CNT_W-1:0]    CNT_MAX = 8'hff;
  localparam logic [CNT_W-1:0]    CNT_MIN = 8'h00;
  localparam logic [CNT_W-1:0]    CNT_RST = 8'hff;

  typedef enum logic [2:0] {
    RATE_NONE  = 3'h0,
    RATE_512   = 3'h1,
    RATE_4     = 3'h3,
    RATE_2     = 3'h2,
    RATE_1_16  = 3'h6
  } fpc_rate_t;

  // Encoder code: top bit marks an attack
  typedef enum logic [2:0] {
    ENC_IDLE     = 3'h0,
    ENC_REL_TEMP = 3'h1,
    ENC_REL_REFL = 3'h2,
    ENC_REL_FAST = 3'h3,
    ENC_ATT_TEMP = 3'h4,
    ENC_ATT_REFL = 3'h5,
    ENC_ATT_FAST = 3'h6
  } fpc_code_t;
  localparam int unsigned ENC_ACT_BIT = 2;

  // Pin input vector positions
  localparam int unsigned IN_REFL_HIGH   = 0;
  localparam int unsigned IN_FWD_OVER    = 1;
  localparam int unsigned IN_FWD_90      = 2;
  localparam int unsigned IN_EMERG_N     = 3;
  localparam int unsigned IN_LIGHTNING_N = 4;
  localparam int unsigned IN_TEMP_HIGH   = 5;
  localparam int unsigned IN_TEMP_LOW    = 6;
  localparam int unsigned IN_VSWR_OK     = 7;
  localparam int unsigned IN_FAST_BELOW  = 8;
  localparam int unsigned IN_ENABLE      = 9;
  localparam int unsigned IN_OPERATE     = 10;
  localparam int unsigned IN_MAN_RESET   = 11;
  localparam int unsigned IN_FB_RESET    = 12;
  localparam int unsigned IN_EXC_FAULT   = 13;
  localparam int unsigned IN_W           = 14;
  // Idle pin levels: active-low alarms high, VSWR flag reads healthy, so no false alarm after reset
  localparam logic [IN_W-1:0] IN_RST     = 14'h0098;

  // Register port
  localparam int unsigned  ADDR_W     = 8;
  localparam logic [7:0]   REG_CTRL   = 8'h00;
  localparam logic [7:0]   REG_STATUS = 8'h04;
  localparam logic [7:0]   REG_COUNT  = 8'h08;
  localparam int unsigned  CTRL_SOFT_RST = 0;
  localparam int unsigned  CTRL_REL_HOLD = 1;
  localparam int unsigned  ST_EXC     = 0;
  localparam int unsigned  ST_REFL    = 1;
  localparam int unsigned  ST_TEMP    = 2;
  localparam int unsigned  ST_EMERG   = 3;
  localparam int unsigned  ST_LIGHT   = 4;
  localparam int unsigned  ST_FAST    = 5;
  localparam int unsigned  ST_ENC_ACT = 6;
  localparam int unsigned  ST_FOLD    = 7;
  localparam int unsigned  ST_CODE_LO = 8;
  localparam int unsigned  ST_HOLD    = 11;
endpackage

// >>> rtl/fpc_step_if.sv
// Link between the controller, the step divider and the counter
interface fpc_step_if;
  fpc_pkg::fpc_rate_t             rate_sel;
  logic                           count_up;
  logic                           step;
  logic                           flash;
  logic [fpc_pkg::CNT_W-1:0]      count;

  modport ctl (output rate_sel, output count_up, input step, input flash, input count);
  modport div (input rate_sel, output step, output flash);
  modport cnt (input step, input count_up, output count);
endinterface

// >>> rtl/fpc_step_div.sv
// Divider producing the selected step pulse and the flash square wave
module fpc_step_div #(
  parameter int unsigned STEP512_CYC = fpc_pkg::STEP512_CYC
) (
  input  wire logic clk,
  input  wire logic rst,
  fpc_step_if.div   sif
);
  typedef struct packed {
    logic [fpc_pkg::PRE_W-1:0]  pre;
    logic [fpc_pkg::TICK_W-1:0] ticks;
    logic                       step;
  } fpc_div_st_t;

  fpc_div_st_t st_reg;
  fpc_div_st_t st_next;

  localparam logic [fpc_pkg::PRE_W-1:0] PRE_LAST = fpc_pkg::PRE_W'(STEP512_CYC - 1);

  always_comb begin
    logic tick;
    logic hit;
    tick    = (st_reg.pre == PRE_LAST);
    hit     = 1'b0;
    st_next = st_reg;
    st_next.pre = tick ? '0 : st_reg.pre + 1'b1;
    if (tick) begin
      st_next.ticks = st_reg.ticks + 1'b1;
    end
    // Slow rates fire on the tick that completes their tick group
    case (sif.rate_sel)
      fpc_pkg::RATE_512:  hit = tick;
      fpc_pkg::RATE_4:    hit = tick && ((st_reg.ticks & fpc_pkg::DIV_4HZ_MASK) == fpc_pkg::DIV_4HZ_MASK);
      fpc_pkg::RATE_2:    hit = tick && ((st_reg.ticks & fpc_pkg::DIV_2HZ_MASK) == fpc_pkg::DIV_2HZ_MASK);
      fpc_pkg::RATE_1_16: hit = tick && (st_reg.ticks == fpc_pkg::DIV_1_16HZ_MASK);
      default:            hit = 1'b0;
    endcase
    st_next.step = hit;
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      st_reg <= '0;
    end else begin
      st_reg <= st_next;
    end
  end

  assign sif.step  = st_reg.step;
  assign sif.flash = st_reg.ticks[fpc_pkg::FLASH_BIT];
endmodule

// >>> rtl/fpc_updown.sv
// Saturating up/down power control counter
module fpc_updown (
  input  wire logic clk,
  input  wire logic rst,
  fpc_step_if.cnt   sif
);
  typedef struct packed {
    logic [fpc_pkg::CNT_W-1:0] count;
  } fpc_cnt_st_t;

  fpc_cnt_st_t st_reg;
  fpc_cnt_st_t st_next;

  always_comb begin
    st_next = st_reg;
    if (sif.step) begin
      if (sif.count_up && st_reg.count != fpc_pkg::CNT_MAX) begin
        st_next.count = st_reg.count + 1'b1;
      end else if (!sif.count_up && st_reg.count != fpc_pkg::CNT_MIN) begin
        st_next.count = st_reg.count - 1'b1;
      end
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      st_reg <= '{count: fpc_pkg::CNT_RST};
    end else begin
      st_reg <= st_next;
    end
  end

  assign sif.count = st_reg.count;
endmodule

// >>> rtl/fpc_top.sv
// Foldback power control: fault latches, priority encoder, step control
module fpc_top #(
  parameter int unsigned STEP512_CYC = fpc_pkg::STEP512_CYC
) (
  input  wire  logic                         CORE_CLK,
  input  wire  logic                         SYS_RST,
  input  wire  logic [fpc_pkg::ADDR_W-1:0]   BUS_ADDR,
  input  wire  logic [31:0]                  BUS_WDATA,
  input  wire  logic                         BUS_WR,
  input  wire  logic                         BUS_RD,
  output logic       [31:0]                  BUS_RDATA,
  input  wire  logic                         REFL_HIGH,
  input  wire  logic                         FWD_OVER,
  input  wire  logic                         FWD_ABOVE_90,
  input  wire  logic                         REFL_EMERG_N,
  input  wire  logic                         LIGHTNING_N,
  input  wire  logic                         TEMP_HIGH,
  input  wire  logic                         TEMP_LOW,
  input  wire  logic                         VSWR_OK,
  input  wire  logic                         FAST_BELOW_REF,
  input  wire  logic                         ENABLE_FAIL,
  input  wire  logic                         OPERATE,
  input  wire  logic                         MANUAL_RESET,
  input  wire  logic                         FOLDBACK_RESET,
  input  wire  logic                         EXCITER_FAULT,
  output logic       [fpc_pkg::CNT_W-1:0]    DAC_CODE,
  output logic                               FOLDBACK_IND,
  output logic                               ANT_RED_ON,
  output logic                               ANT_GREEN_ON,
  output logic                               EXC_RED_ON,
  output logic                               EXC_GREEN_ON,
  output logic                               TEMP_IND,
  output logic                               LIGHTNING_IND,
  output logic                               ALARM_ON
);
  typedef struct packed {
    logic [fpc_pkg::IN_W-1:0]  sync1;
    logic [fpc_pkg::IN_W-1:0]  sync2;
    logic                      exc_lat;
    logic                      refl_lat;
    logic                      temp_lat;
    logic                      emerg_lat;
    logic                      light_lat;
    logic                      fast_lat;
    logic                      emerg_hold;
    logic                      enc_act;
    fpc_pkg::fpc_code_t        code;
    logic                      soft_rst;
    logic                      rel_hold;
    logic [31:0]               rdata;
    logic [fpc_pkg::CNT_W-1:0] dac;
    logic                      fold_ind;
    logic                      ant_red;
    logic                      ant_green;
    logic                      exc_red;
    logic                      exc_green;
    logic                      temp_ind;
    logic                      light_ind;
    logic                      alarm;
  } fpc_top_st_t;

  fpc_top_st_t st_reg;
  fpc_top_st_t st_next;
  fpc_step_if  sif ();

  logic [fpc_pkg::IN_W-1:0] pins;

  assign pins[fpc_pkg::IN_REFL_HIGH]   = REFL_HIGH;
  assign pins[fpc_pkg::IN_FWD_OVER]    = FWD_OVER;
  assign pins[fpc_pkg::IN_FWD_90]      = FWD_ABOVE_90;
  assign pins[fpc_pkg::IN_EMERG_N]     = REFL_EMERG_N;
  assign pins[fpc_pkg::IN_LIGHTNING_N] = LIGHTNING_N;
  assign pins[fpc_pkg::IN_TEMP_HIGH]   = TEMP_HIGH;
  assign pins[fpc_pkg::IN_TEMP_LOW]    = TEMP_LOW;
  assign pins[fpc_pkg::IN_VSWR_OK]     = VSWR_OK;
  assign pins[fpc_pkg::IN_FAST_BELOW]  = FAST_BELOW_REF;
  assign pins[fpc_pkg::IN_ENABLE]      = ENABLE_FAIL;
  assign pins[fpc_pkg::IN_OPERATE]     = OPERATE;
  assign pins[fpc_pkg::IN_MAN_RESET]   = MANUAL_RESET;
  assign pins[fpc_pkg::IN_FB_RESET]    = FOLDBACK_RESET;
  assign pins[fpc_pkg::IN_EXC_FAULT]   = EXCITER_FAULT;

  fpc_step_div #(
    .STEP512_CYC (STEP512_CYC)
  ) u_div (
    .clk (CORE_CLK),
    .rst (SYS_RST),
    .sif (sif.div)
  );

  fpc_updown u_cnt (
    .clk (CORE_CLK),
    .rst (SYS_RST),
    .sif (sif.cnt)
  );

  // Rate follows the registered code; one cycle of lag is negligible
  always_comb begin
    case (st_reg.code)
      fpc_pkg::ENC_ATT_FAST: sif.rate_sel = fpc_pkg::RATE_512;
      fpc_pkg::ENC_ATT_REFL: sif.rate_sel = fpc_pkg::RATE_4;
      fpc_pkg::ENC_ATT_TEMP: sif.rate_sel = fpc_pkg::RATE_1_16;
      fpc_pkg::ENC_REL_FAST: sif.rate_sel = fpc_pkg::RATE_512;
      fpc_pkg::ENC_REL_REFL: sif.rate_sel = fpc_pkg::RATE_2;
      fpc_pkg::ENC_REL_TEMP: sif.rate_sel = fpc_pkg::RATE_1_16;
      default:               sif.rate_sel = fpc_pkg::RATE_NONE;
    endcase
  end

  // Attack codes count down, release codes count up
  assign sif.count_up = ~st_reg.code[fpc_pkg::ENC_ACT_BIT];

  always_comb begin
    logic [fpc_pkg::IN_W-1:0] s;
    logic enable;
    logic refl_att;
    logic temp_att;
    logic emerg;
    logic light;
    logic fast_att;
    logic refl_rel;
    logic temp_rel;
    logic fast_rel;
    logic clr;
    logic exc_set;
    logic wr_ctrl;
    s        = st_reg.sync2;
    enable   = s[fpc_pkg::IN_ENABLE];
    st_next  = st_reg;
    st_next.sync1 = pins;
    st_next.sync2 = st_reg.sync1;

    // Forward path needs both comparators; either path keeps the attack up
    refl_att = (s[fpc_pkg::IN_REFL_HIGH] | (s[fpc_pkg::IN_FWD_OVER] & s[fpc_pkg::IN_FWD_90])) & enable;
    temp_att = s[fpc_pkg::IN_TEMP_HIGH] & enable;
    emerg    = ~s[fpc_pkg::IN_EMERG_N];
    light    = ~s[fpc_pkg::IN_LIGHTNING_N];
    fast_att = (emerg | light) & enable;
    exc_set  = s[fpc_pkg::IN_EXC_FAULT] & enable;

    refl_rel = s[fpc_pkg::IN_OPERATE] & s[fpc_pkg::IN_VSWR_OK] & st_reg.refl_lat & ~st_reg.rel_hold;
    temp_rel = s[fpc_pkg::IN_TEMP_LOW] & st_reg.temp_lat & ~st_reg.rel_hold;
    fast_rel = s[fpc_pkg::IN_FAST_BELOW] & st_reg.fast_lat & ~st_reg.rel_hold;

    // Attacks outrank releases; a latched fault never blocks a new attack
    if (fast_att) begin
      st_next.code = fpc_pkg::ENC_ATT_FAST;
    end else if (refl_att) begin
      st_next.code = fpc_pkg::ENC_ATT_REFL;
    end else if (temp_att) begin
      st_next.code = fpc_pkg::ENC_ATT_TEMP;
    end else if (fast_rel) begin
      st_next.code = fpc_pkg::ENC_REL_FAST;
    end else if (refl_rel) begin
      st_next.code = fpc_pkg::ENC_REL_REFL;
    end else if (temp_rel) begin
      st_next.code = fpc_pkg::ENC_REL_TEMP;
    end else begin
      st_next.code = fpc_pkg::ENC_IDLE;
    end

    // Self-holding gate, released only by foldback reset; a live emergency keeps it set
    st_next.emerg_hold = emerg | (st_reg.emerg_hold & ~s[fpc_pkg::IN_FB_RESET]);

    // Set wins over clear on every latch
    clr = s[fpc_pkg::IN_MAN_RESET] | st_reg.soft_rst;
    st_next.exc_lat   = exc_set | (st_reg.exc_lat & ~clr);
    st_next.refl_lat  = refl_att | (st_reg.refl_lat & ~clr);
    st_next.temp_lat  = temp_att | (st_reg.temp_lat & ~clr);
    st_next.emerg_lat = st_reg.emerg_hold | (st_reg.emerg_lat & ~clr);
    st_next.light_lat = light | (st_reg.light_lat & ~clr);
    st_next.fast_lat  = fast_att | (st_reg.fast_lat & ~clr);
    st_next.enc_act   = st_reg.code[fpc_pkg::ENC_ACT_BIT] | (st_reg.enc_act & ~clr);

    // Indicators
    st_next.dac       = sif.count;
    st_next.fold_ind  = (sif.count != fpc_pkg::CNT_MAX) | st_reg.enc_act;
    st_next.ant_red   = st_reg.emerg_lat ? sif.flash : ~s[fpc_pkg::IN_VSWR_OK];
    st_next.ant_green = ~(st_reg.refl_lat | st_reg.emerg_lat);
    st_next.exc_red   = st_reg.exc_lat;
    st_next.exc_green = ~st_reg.exc_lat;
    st_next.temp_ind  = st_reg.temp_lat;
    st_next.light_ind = st_reg.light_lat;
    st_next.alarm     = st_reg.exc_lat | st_reg.refl_lat | st_reg.temp_lat | st_reg.emerg_lat
                        | st_reg.light_lat | ~s[fpc_pkg::IN_VSWR_OK];

    // Register port
    wr_ctrl          = BUS_WR && (BUS_ADDR == fpc_pkg::REG_CTRL);
    st_next.soft_rst = wr_ctrl && BUS_WDATA[fpc_pkg::CTRL_SOFT_RST];
    if (wr_ctrl) begin
      st_next.rel_hold = BUS_WDATA[fpc_pkg::CTRL_REL_HOLD];
    end
    st_next.rdata = '0;
    if (BUS_RD) begin
      case (BUS_ADDR)
        fpc_pkg::REG_CTRL: begin
          st_next.rdata[fpc_pkg::CTRL_REL_HOLD] = st_reg.rel_hold;
        end
        fpc_pkg::REG_STATUS: begin
          st_next.rdata[fpc_pkg::ST_EXC]     = st_reg.exc_lat;
          st_next.rdata[fpc_pkg::ST_REFL]    = st_reg.refl_lat;
          st_next.rdata[fpc_pkg::ST_TEMP]    = st_reg.temp_lat;
          st_next.rdata[fpc_pkg::ST_EMERG]   = st_reg.emerg_lat;
          st_next.rdata[fpc_pkg::ST_LIGHT]   = st_reg.light_lat;
          st_next.rdata[fpc_pkg::ST_FAST]    = st_reg.fast_lat;
          st_next.rdata[fpc_pkg::ST_ENC_ACT] = st_reg.enc_act;
          st_next.rdata[fpc_pkg::ST_FOLD]    = st_reg.fold_ind;
          st_next.rdata[fpc_pkg::ST_CODE_LO +: 3] = st_reg.code;
          st_next.rdata[fpc_pkg::ST_HOLD]    = st_reg.emerg_hold;
        end
        fpc_pkg::REG_COUNT: begin
          st_next.rdata[fpc_pkg::CNT_W-1:0] = sif.count;
        end
        default: st_next.rdata = '0;
      endcase
    end
  end

  always_ff @(posedge CORE_CLK or posedge SYS_RST) begin
    if (SYS_RST) begin
      st_reg           <= '0;
      st_reg.sync1     <= fpc_pkg::IN_RST;
      st_reg.sync2     <= fpc_pkg::IN_RST;
      st_reg.code      <= fpc_pkg::ENC_IDLE;
      st_reg.dac       <= fpc_pkg::CNT_RST;
      st_reg.ant_green <= 1'b1;
      st_reg.exc_green <= 1'b1;
    end else begin
      st_reg <= st_next;
    end
  end

  assign BUS_RDATA     = st_reg.rdata;
  assign DAC_CODE      = st_reg.dac;
  assign FOLDBACK_IND  = st_reg.fold_ind;
  assign ANT_RED_ON    = st_reg.ant_red;
  assign ANT_GREEN_ON  = st_reg.ant_green;
  assign EXC_RED_ON    = st_reg.exc_red;
  assign EXC_GREEN_ON  = st_reg.exc_green;
  assign TEMP_IND      = st_reg.temp_ind;
  assign LIGHTNING_IND = st_reg.light_ind;
  assign ALARM_ON      = st_reg.alarm;
endmodule

// >>> verification/fpc_analog_model.sv
// Comparator front end that drives the foldback control pins
module fpc_analog_model (
  input  wire logic       clk,
  input  wire logic [7:0] dac_code,
  input  wire logic       refl_bad,
  input  wire logic       fwd_surge,
  input  wire logic       mismatch,
  output logic            refl_high,
  output logic            fwd_over,
  output logic            fwd_above_90,
  output logic            vswr_ok
);
  timeunit 1ns;
  timeprecision 1ps;
  // Forward sample tracks the reference, so the 90 percent point is a code
  localparam logic [7:0] LVL_90 = 8'he5;
  initial begin
    refl_high    = 1'b0;
    fwd_over     = 1'b0;
    fwd_above_90 = 1'b1;
    vswr_ok      = 1'b1;
  end
  always @(posedge clk) begin
    refl_high    <= refl_bad;
    fwd_over     <= fwd_surge;
    fwd_above_90 <= dac_code > LVL_90;
    vswr_ok      <= !mismatch;
  end
endmodule

// >>> verification/fpc_sva.sv
// Assertions on the foldback power control ports
module fpc_sva (
  input wire logic        CORE_CLK,
  input wire logic        SYS_RST,
  input wire logic        BUS_RD,
  input wire logic [31:0] BUS_RDATA,
  input wire logic        REFL_HIGH,
  input wire logic        FWD_OVER,
  input wire logic        FWD_ABOVE_90,
  input wire logic        REFL_EMERG_N,
  input wire logic        LIGHTNING_N,
  input wire logic        TEMP_HIGH,
  input wire logic        TEMP_LOW,
  input wire logic        VSWR_OK,
  input wire logic        FAST_BELOW_REF,
  input wire logic        ENABLE_FAIL,
  input wire logic        OPERATE,
  input wire logic        MANUAL_RESET,
  input wire logic        FOLDBACK_RESET,
  input wire logic        EXCITER_FAULT,
  input wire logic [7:0]  DAC_CODE,
  input wire logic        FOLDBACK_IND,
  input wire logic        ANT_RED_ON,
  input wire logic        ANT_GREEN_ON,
  input wire logic        EXC_RED_ON
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking @(posedge CORE_CLK);
  endclocking
  default disable iff (SYS_RST);
  logic quiet;
  // No pin pattern that could start an attack; pipeline needs 8 cycles to drain
  assign quiet = !REFL_HIGH && !(FWD_OVER && FWD_ABOVE_90) && REFL_EMERG_N && LIGHTNING_N && !TEMP_HIGH;

  rdata_slot_a: assert property (!$past(BUS_RD) |-> BUS_RDATA == 32'h0)
    else $error("read data outside its slot");
  dac_step_a: assert property ($changed(DAC_CODE) |->
    (DAC_CODE == $past(DAC_CODE) + 8'h01 && $past(DAC_CODE) != 8'hff) ||
    (DAC_CODE == $past(DAC_CODE) - 8'h01 && $past(DAC_CODE) != 8'h00))
    else $error("power code jumped or wrapped");
  idle_hold_a: assert property (
    (quiet && !TEMP_LOW && !FAST_BELOW_REF && !OPERATE) [*8] |=> $stable(DAC_CODE))
    else $error("power code moved with no request");
  attack_down_a: assert property ((REFL_HIGH && ENABLE_FAIL) [*8] |=> DAC_CODE <= $past(DAC_CODE))
    else $error("power code rose during an attack");
  release_up_a: assert property (quiet [*8] |=> DAC_CODE >= $past(DAC_CODE))
    else $error("power code fell with no attack");
  foldback_shown_a: assert property (DAC_CODE != 8'hff |-> FOLDBACK_IND)
    else $error("foldback lamp off below full power");
  exc_set_a: assert property ((EXCITER_FAULT && ENABLE_FAIL) [*2] |-> ##[1:6] EXC_RED_ON)
    else $error("exciter fault not latched");
  exc_clear_a: assert property ((MANUAL_RESET && !EXCITER_FAULT) [*8] |-> !EXC_RED_ON)
    else $error("exciter latch survived manual reset");
  yellow_ant_a: assert property (
    (!VSWR_OK && quiet && !FWD_OVER && MANUAL_RESET && FOLDBACK_RESET) [*8] |-> ANT_RED_ON && ANT_GREEN_ON)
    else $error("antenna not yellow on mismatch");

  fold_seen_c: cover property ($fell(FOLDBACK_IND));
  exc_seen_c: cover property ($rose(EXC_RED_ON));
  yellow_seen_c: cover property (ANT_RED_ON && ANT_GREEN_ON);
endmodule

bind fpc_top fpc_sva chk_u (.CORE_CLK, .SYS_RST, .BUS_RD, .BUS_RDATA, .REFL_HIGH, .FWD_OVER, .FWD_ABOVE_90,
  .REFL_EMERG_N, .LIGHTNING_N, .TEMP_HIGH, .TEMP_LOW, .VSWR_OK, .FAST_BELOW_REF, .ENABLE_FAIL, .OPERATE,
  .MANUAL_RESET, .FOLDBACK_RESET, .EXCITER_FAULT, .DAC_CODE, .FOLDBACK_IND, .ANT_RED_ON, .ANT_GREEN_ON,
  .EXC_RED_ON);

// >>> verification/tb_top.sv
// Directed bench of the foldback power control
module tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  logic        CORE_CLK       = 1'b0;
  logic        SYS_RST        = 1'b1;
  logic [7:0]  BUS_ADDR       = 8'h00;
  logic [31:0] BUS_WDATA      = 32'h0;
  logic        BUS_WR         = 1'b0;
  logic        BUS_RD         = 1'b0;
  logic        REFL_EMERG_N   = 1'b1;
  logic        LIGHTNING_N    = 1'b1;
  logic        TEMP_HIGH      = 1'b0;
  logic        TEMP_LOW       = 1'b0;
  logic        FAST_BELOW_REF = 1'b0;
  logic        ENABLE_FAIL    = 1'b1;
  logic        OPERATE        = 1'b0;
  logic        MANUAL_RESET   = 1'b0;
  logic        FOLDBACK_RESET = 1'b0;
  logic        EXCITER_FAULT  = 1'b0;
  logic        refl_bad       = 1'b0;
  logic        fwd_surge      = 1'b0;
  logic        mismatch       = 1'b0;
  logic [31:0] BUS_RDATA;
  logic [7:0]  DAC_CODE;
  logic [7:0]  snap;
  logic        REFL_HIGH, FWD_OVER, FWD_ABOVE_90, VSWR_OK, FOLDBACK_IND, ANT_RED_ON, ANT_GREEN_ON;
  logic        EXC_RED_ON, EXC_GREEN_ON, TEMP_IND, LIGHTNING_IND, ALARM_ON;
  int          n_mismatch     = 0;
  int          total_checks   = 0;

  always #4 CORE_CLK = ~CORE_CLK;

  // Short base tick keeps the slow rates inside the run budget
  fpc_top #(.STEP512_CYC(4)) dut_u (.CORE_CLK, .SYS_RST, .BUS_ADDR, .BUS_WDATA, .BUS_WR, .BUS_RD,
    .BUS_RDATA, .REFL_HIGH, .FWD_OVER, .FWD_ABOVE_90, .REFL_EMERG_N, .LIGHTNING_N, .TEMP_HIGH, .TEMP_LOW,
    .VSWR_OK, .FAST_BELOW_REF, .ENABLE_FAIL, .OPERATE, .MANUAL_RESET, .FOLDBACK_RESET, .EXCITER_FAULT,
    .DAC_CODE, .FOLDBACK_IND, .ANT_RED_ON, .ANT_GREEN_ON, .EXC_RED_ON, .EXC_GREEN_ON, .TEMP_IND,
    .LIGHTNING_IND, .ALARM_ON);

  fpc_analog_model model_u (.clk(CORE_CLK), .dac_code(DAC_CODE), .refl_bad, .fwd_surge, .mismatch,
    .refl_high(REFL_HIGH), .fwd_over(FWD_OVER), .fwd_above_90(FWD_ABOVE_90), .vswr_ok(VSWR_OK));

  task automatic tick(input int n);
    repeat (n) @(posedge CORE_CLK);
  endtask

  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    total_checks++;
    if (got !== exp) begin
      n_mismatch++;
      $display("wrong value %s expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    BUS_ADDR  <= a;
    BUS_WDATA <= d;
    BUS_WR    <= 1'b1;
    @(posedge CORE_CLK);
    BUS_WR <= 1'b0;
  endtask

  task automatic rchk(input string what, input logic [7:0] a, input logic [31:0] exp, input logic [31:0] msk);
    BUS_ADDR <= a;
    BUS_RD   <= 1'b1;
    @(posedge CORE_CLK);
    BUS_RD <= 1'b0;
    @(negedge CORE_CLK);
    chk(what, exp, BUS_RDATA & msk);
    @(posedge CORE_CLK);
  endtask

  task automatic man_reset();
    MANUAL_RESET <= 1'b1;
    tick(4);
    MANUAL_RESET <= 1'b0;
    tick(8);
  endtask

  // Two changes are awaited but only the second is timed, because the shared tick leaves the first one early
  task automatic step_chk(input string what, input int per, input logic up);
    logic [7:0] v;
    int         n;
    for (int k = 0; k < 2; k++) begin
      v = DAC_CODE;
      n = 0;
      while (DAC_CODE === v && n < per + 16) begin
        tick(1);
        n++;
      end
    end
    chk({what, " period"}, per, n);
    chk({what, " step"}, {24'h0, up ? v + 8'h01 : v - 8'h01}, DAC_CODE);
  endtask

  task automatic report_and_stop();
    $display("checks %0d mismatches %0d", total_checks, n_mismatch);
    if (n_mismatch == 0 && total_checks > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask

  initial begin
    tick(99000);
    n_mismatch++;
    report_and_stop();
  end

  initial begin
    tick(12);
    SYS_RST <= 1'b0;
    tick(8);
    rchk("ctrl", fpc_pkg::REG_CTRL, 32'h0, 32'hffffffff);
    rchk("status", fpc_pkg::REG_STATUS, 32'h0, 32'hffffffff);
    rchk("count", fpc_pkg::REG_COUNT, 32'hff, 32'hffffffff);
    rchk("unmapped", 8'h0c, 32'h0, 32'hffffffff);
    wr(fpc_pkg::REG_CTRL, 32'h2);
    rchk("ctrl hold", fpc_pkg::REG_CTRL, 32'h2, 32'hffffffff);
    wr(fpc_pkg::REG_CTRL, 32'h0);
    // Exciter latch needs the enable gate
    ENABLE_FAIL   <= 1'b0;
    EXCITER_FAULT <= 1'b1;
    tick(8);
    chk("exc gated", 32'h1, {EXC_RED_ON, EXC_GREEN_ON});
    ENABLE_FAIL <= 1'b1;
    tick(8);
    EXCITER_FAULT <= 1'b0;
    tick(8);
    chk("exc lamps", 32'h2, {EXC_RED_ON, EXC_GREEN_ON});
    man_reset();
    chk("exc cleared", 32'h1, {EXC_RED_ON, EXC_GREEN_ON});
    chk("alarm off", 32'h0, ALARM_ON);
    mismatch       <= 1'b1;
    MANUAL_RESET   <= 1'b1;
    FOLDBACK_RESET <= 1'b1;
    tick(12);
    chk("antenna", 32'h3, {ANT_RED_ON, ANT_GREEN_ON});
    mismatch       <= 1'b0;
    MANUAL_RESET   <= 1'b0;
    FOLDBACK_RESET <= 1'b0;
    tick(8);
    // Forward surge steps down until the 90 percent comparator drops
    fwd_surge <= 1'b1;
    for (int i = 0; i < 20000 && DAC_CODE !== 8'he5; i++) tick(1);
    tick(1500);
    chk("dac at 90", 32'he5, DAC_CODE);
    chk("foldback", 32'h1, FOLDBACK_IND);
    rchk("refl latch", fpc_pkg::REG_STATUS, 32'hc2, 32'h7ff);
    fwd_surge <= 1'b0;
    OPERATE   <= 1'b1;
    tick(20);
    rchk("refl release", fpc_pkg::REG_STATUS, 32'h200, 32'h700);
    step_chk("refl release", 1024, 1'b1);
    wr(fpc_pkg::REG_CTRL, 32'h2);
    tick(8);
    snap = DAC_CODE;
    tick(1100);
    chk("release held", {24'h0, snap}, DAC_CODE);
    wr(fpc_pkg::REG_CTRL, 32'h0);
    OPERATE <= 1'b0;
    man_reset();
    rchk("after reset", fpc_pkg::REG_STATUS, 32'h80, 32'h7ff);
    REFL_EMERG_N <= 1'b0;
    tick(20);
    step_chk("fast attack", 4, 1'b0);
    REFL_EMERG_N   <= 1'b1;
    FAST_BELOW_REF <= 1'b1;
    tick(20);
    step_chk("fast release", 4, 1'b1);
    tick(1100);
    chk("saturated", 32'hff, DAC_CODE);
    LIGHTNING_N <= 1'b0;
    tick(6);
    LIGHTNING_N <= 1'b1;
    tick(8);
    chk("lightning lamp", 32'h1, LIGHTNING_IND);
    man_reset();
    rchk("emerg held", fpc_pkg::REG_STATUS, 32'h8, 32'h8);
    FOLDBACK_RESET <= 1'b1;
    man_reset();
    rchk("latches clear", fpc_pkg::REG_STATUS, 32'h0, 32'h3f);
    FOLDBACK_RESET <= 1'b0;
    FAST_BELOW_REF <= 1'b0;
    refl_bad  <= 1'b1;
    TEMP_HIGH <= 1'b1;
    tick(12);
    rchk("code both", fpc_pkg::REG_STATUS, 32'h540, 32'h740);
    refl_bad <= 1'b0;
    tick(20);
    rchk("code temp", fpc_pkg::REG_STATUS, 32'h400, 32'h700);
    chk("temp lamp", 32'h1, TEMP_IND);
    step_chk("temp attack", 32768, 1'b0);
    TEMP_HIGH <= 1'b0;
    tick(12);
    rchk("temp ended", fpc_pkg::REG_STATUS, 32'h0, 32'h700);
    TEMP_LOW <= 1'b1;
    tick(12);
    rchk("temp release", fpc_pkg::REG_STATUS, 32'h100, 32'h700);
    TEMP_LOW <= 1'b0;
    // Soft clear from the control register empties every latch like the switch
    wr(fpc_pkg::REG_CTRL, 32'h1);
    tick(4);
    rchk("soft clear", fpc_pkg::REG_STATUS, 32'h0, 32'h7f);
    chk("temp lamp off", 32'h0, TEMP_IND);
    report_and_stop();
  end
endmodule
